/* rpc_pkg.sv */
// Shared constants, types and register map of the reset and power controller
package rpc_pkg;

  // ---------------------------------------------------------------
  // Register bus geometry and map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          NUM_PORTS     = 4;
  localparam logic [3:0]  ADDR_PORT0    = 4'h0;
  localparam logic [3:0]  ADDR_PORT3    = 4'h3;
  localparam logic [3:0]  ADDR_SP       = 4'h4;
  localparam logic [3:0]  ADDR_PWR_CTL  = 4'h5;
  localparam logic [3:0]  ADDR_SER_BUF  = 4'h6;
  localparam logic [3:0]  ADDR_GEN_SFR  = 4'h7;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0]  PORT_RST_VAL  = 8'hff;
  localparam logic [7:0]  SP_RST_VAL    = 8'h07;
  localparam logic [7:0]  SFR_RST_VAL   = 8'h00;
  localparam logic [7:0]  PWR_KEEP_MASK = 8'h10;
  localparam int          IDLE_BIT      = 0;
  localparam int          PDOWN_BIT     = 1;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // ---------------------------------------------------------------
  // Machine cycle timing: six states of two phases
  // ---------------------------------------------------------------
  localparam logic [2:0]  LAST_STATE    = 3'h5;
  localparam logic [2:0]  FIRST_STATE   = 3'h0;
  localparam logic [2:0]  SAMPLE_STATE  = 3'h4;
  localparam logic        SAMPLE_PHASE  = 1'b1;
  localparam int          RST_QUAL_MC   = 2;
  localparam int          GLITCH_CYC    = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RPC_RUN,
    RPC_IDLE,
    RPC_DOWN
  } rpc_mode_e;

  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] port_latch;
    logic [7:0]                stack_ptr;
  } rpc_sfr_view_s;

  typedef struct packed {
    logic       sys_rst;
    logic       osc_run;
    rpc_mode_e  mode;
    logic       phase;
    logic [2:0] state;
  } rpc_status_s;

endpackage : rpc_pkg

/* rpc_top.sv */
// Clock conditioning, power modes and reset sequencing of the controller core
`timescale 1ns/1ps
module rpc_top
  import rpc_pkg::*;
#(
  parameter int GLITCH_CYCLES = GLITCH_CYC,
  parameter int QUAL_CYCLES   = RST_QUAL_MC
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              ext_rst_i,
  input  wire logic              irq_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   cpu_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   osc_run_o,
  output logic                   sys_rst_o,
  output logic                   ale_weak_high_o,
  output logic                   program_fetch_strobe_weak_high_o,
  output rpc_sfr_view_s          sfr_o,
  output rpc_status_s            status_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_sample_point(input logic [2:0] st, input logic ph);
    is_sample_point = (st == SAMPLE_STATE) && (ph == SAMPLE_PHASE);
  endfunction : is_sample_point

  function automatic logic is_port_addr(input logic [ADDR_W-1:0] a);
    is_port_addr = (a >= ADDR_PORT0) && (a <= ADDR_PORT3);
  endfunction : is_port_addr

  localparam int FLT_W = $clog2(GLITCH_CYCLES + 1);
  localparam int QC_W  = $clog2(QUAL_CYCLES + 1);
  localparam logic [FLT_W-1:0] FLT_LAST = FLT_W'(GLITCH_CYCLES - 1);
  localparam logic [QC_W-1:0]  QC_FULL  = QC_W'(QUAL_CYCLES);
  localparam logic [QC_W-1:0]  QC_PREV  = QC_W'(QUAL_CYCLES - 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                        phase;
  logic [2:0]                  state;
  logic                        osc_run;
  logic                        tick_state;
  logic                        sample_now;
  logic [FLT_W-1:0]            flt_cnt;
  logic                        rst_level;
  logic [QC_W-1:0]             qual_cnt;
  logic                        sys_rst;
  rpc_mode_e                   mode;
  logic [7:0]                  pwr_ctl;
  logic [NUM_PORTS-1:0][7:0]   port_latch;
  logic [7:0]                  stack_ptr;
  logic [7:0]                  ser_buf;
  logic [7:0]                  gen_sfr;
  logic                        wr_ok;
  logic [7:0]                  next_rdata;
  rpc_status_s                 status;

  assign tick_state = osc_run && phase;
  assign sample_now = osc_run && is_sample_point(state, phase);
  assign wr_ok      = wr_i && !sys_rst;

  // ---------------------------------------------------------------
  // Oscillator run control
  // ---------------------------------------------------------------
  // Filtered reset restarts a stopped oscillator so it can be qualified
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_run <= 1'b1;
    end else if (rst_level) begin
      osc_run <= 1'b1;
    end else if (mode == RPC_DOWN) begin
      osc_run <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Phase and state sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= 1'b0;
    end else if (osc_run) begin
      phase <= ~phase;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= FIRST_STATE;
    end else if (tick_state) begin
      state <= (state == LAST_STATE) ? FIRST_STATE : state + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Reset input glitch filter
  // ---------------------------------------------------------------
  // Level changes only after the input holds its new value long enough
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flt_cnt   <= '0;
      rst_level <= 1'b0;
    end else if (ext_rst_i == rst_level) begin
      flt_cnt   <= '0;
    end else if (flt_cnt == FLT_LAST) begin
      flt_cnt   <= '0;
      rst_level <= ext_rst_i;
    end else begin
      flt_cnt   <= flt_cnt + FLT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Reset qualification at the sample point
  // ---------------------------------------------------------------
  // Consecutive high samples, held once full
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      qual_cnt <= '0;
    end else if (sample_now) begin
      if (!rst_level) begin
        qual_cnt <= '0;
      end else if (qual_cnt != QC_FULL) begin
        qual_cnt <= qual_cnt + QC_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_rst <= 1'b1;
    end else if (sample_now) begin
      // Compare against one less, as this sample is not yet counted in qual_cnt
      sys_rst <= rst_level && (qual_cnt >= QC_PREV);
    end
  end

  // ---------------------------------------------------------------
  // Power mode
  // ---------------------------------------------------------------
  // Power-down outranks idle when both request bits are set
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= RPC_RUN;
    end else if (sys_rst) begin
      mode <= RPC_RUN;
    end else begin
      unique case (mode)
        RPC_RUN: begin
          if (pwr_ctl[PDOWN_BIT]) begin
            mode <= RPC_DOWN;
          end else if (pwr_ctl[IDLE_BIT]) begin
            mode <= RPC_IDLE;
          end
        end
        RPC_IDLE: begin
          if (irq_i) begin
            mode <= RPC_RUN;
          end
        end
        RPC_DOWN: begin
          mode <= RPC_DOWN;
        end
        default: begin
          mode <= RPC_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power control register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_ctl <= SFR_RST_VAL;
    end else if (sys_rst) begin
      pwr_ctl <= pwr_ctl & PWR_KEEP_MASK;
    end else if (wr_ok && addr_i == ADDR_PWR_CTL) begin
      pwr_ctl <= wdata_i;
    end else if (mode == RPC_IDLE && irq_i && !pwr_ctl[PDOWN_BIT]) begin
      pwr_ctl[IDLE_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Special function registers
  // ---------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          port_latch[gp] <= PORT_RST_VAL;
        end else if (sys_rst) begin
          port_latch[gp] <= PORT_RST_VAL;
        end else if (wr_ok && addr_i == ADDR_PORT0 + ADDR_W'(gp)) begin
          port_latch[gp] <= wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stack_ptr <= SP_RST_VAL;
    end else if (sys_rst) begin
      stack_ptr <= SP_RST_VAL;
    end else if (wr_ok && addr_i == ADDR_SP) begin
      stack_ptr <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gen_sfr <= SFR_RST_VAL;
    end else if (sys_rst) begin
      gen_sfr <= SFR_RST_VAL;
    end else if (wr_ok && addr_i == ADDR_GEN_SFR) begin
      gen_sfr <= wdata_i;
    end
  end

  // Serial buffer survives the qualified reset, only power-on clears it
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_buf <= SFR_RST_VAL;
    end else if (wr_ok && addr_i == ADDR_SER_BUF) begin
      ser_buf <= wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  assign status = '{sys_rst: sys_rst, osc_run: osc_run, mode: mode, phase: phase, state: state};

  always_comb begin
    next_rdata = READ_ZERO;
    if (is_port_addr(addr_i)) begin
      next_rdata = port_latch[addr_i[1:0]];
    end else begin
      unique case (addr_i)
        ADDR_SP:      next_rdata = stack_ptr;
        ADDR_PWR_CTL: next_rdata = pwr_ctl;
        ADDR_SER_BUF: next_rdata = ser_buf;
        ADDR_GEN_SFR: next_rdata = gen_sfr;
        ADDR_STATUS:  next_rdata = status;
        default:      next_rdata = READ_ZERO;
      endcase
    end
  end

  // Read data stand in each cycle that follows a cycle with rd_i high, zero otherwise
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= READ_ZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= READ_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // Clock enables and outputs
  // ---------------------------------------------------------------
  // One shared tick keeps peripherals in step with the processor
  assign cpu_clk_en_o    = tick_state && (mode == RPC_RUN);
  assign periph_clk_en_o = tick_state && (mode != RPC_DOWN);
  assign osc_run_o       = osc_run;
  assign sys_rst_o       = sys_rst;
  assign ale_weak_high_o = sys_rst;
  assign program_fetch_strobe_weak_high_o = sys_rst;
  assign sfr_o           = '{port_latch: port_latch, stack_ptr: stack_ptr};
  assign status_o        = status;

endmodule : rpc_top

/* rpc_unused_guard.sv */
// Holds no logic: the whole block sits in rpc_top

/* rpc_monitor.sv */
// Assertion checker for the reset and power controller
`timescale 1ns/1ps
module rpc_monitor
  import rpc_pkg::*;
#(
  parameter int GLITCH_CYCLES = GLITCH_CYC,
  parameter int QUAL_CYCLES   = RST_QUAL_MC
) (
  input wire logic          mclk_i,
  input wire logic          rstn_i,
  input wire logic          ext_rst_i,
  input wire logic          irq_i,
  input wire logic          wr_i,
  input wire logic          cpu_clk_en_o,
  input wire logic          periph_clk_en_o,
  input wire logic          sys_rst_o,
  input wire logic          ale_weak_high_o,
  input wire logic          program_fetch_strobe_weak_high_o,
  input wire rpc_sfr_view_s sfr_o,
  input wire rpc_status_s   status_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [5:0] lo_cnt;
  logic [7:0] hi_age;
  // ----------------------------------------
  // Cycles since the pin last stayed low long enough
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lo_cnt <= 6'h00;
      hi_age <= 8'h00;
    end else begin
      lo_cnt <= ext_rst_i ? 6'h00 : lo_cnt + {5'h00, lo_cnt != 6'h3f};
      hi_age <= (int'(lo_cnt) >= GLITCH_CYCLES) ? 8'h00 : hi_age + {7'h00, hi_age != 8'hff};
    end
  end
  AST_HALF_RATE: assert property (periph_clk_en_o |=> !periph_clk_en_o && !cpu_clk_en_o)
    else $error("enable pulse too long");
  AST_IDLE_CPU: assert property (status_o.mode == RPC_IDLE |-> !cpu_clk_en_o)
    else $error("cpu enable in idle");
  AST_IDLE_PERIPH: assert property (status_o.mode == RPC_IDLE |-> ##[0:1] periph_clk_en_o)
    else $error("peripherals stalled in idle");
  AST_IRQ_WAKE: assert property (status_o.mode == RPC_IDLE && irq_i && !wr_i |=> status_o.mode == RPC_RUN)
    else $error("interrupt did not end idle");
  AST_DOWN_STOP: assert property (status_o.mode == RPC_DOWN |-> !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clock enable in power down");
  AST_DOWN_OSC: assert property (
    status_o.mode == RPC_DOWN && int'(lo_cnt) >= GLITCH_CYCLES |=> !status_o.osc_run)
    else $error("oscillator runs in power down");
  AST_DOWN_HOLD: assert property (
    status_o.mode == RPC_DOWN && !sys_rst_o |=> status_o.mode == RPC_DOWN || sys_rst_o)
    else $error("power down left without reset");
  AST_SAMPLE_POINT: assert property ($changed(sys_rst_o) |->
    $past(status_o.state) == SAMPLE_STATE && $past(status_o.phase) == SAMPLE_PHASE)
    else $error("reset changed off the sample point");
  AST_QUAL: assert property ($rose(sys_rst_o) |-> int'(hi_age) >= 12 * (QUAL_CYCLES - 1))
    else $error("reset taken on too short a pulse");
  AST_RESET_LOAD: assert property (sys_rst_o |=>
    sfr_o.stack_ptr == SP_RST_VAL && sfr_o.port_latch == {NUM_PORTS{PORT_RST_VAL}})
    else $error("reset values not loaded");
  AST_STROBES: assert property (sys_rst_o |-> ale_weak_high_o && program_fetch_strobe_weak_high_o)
    else $error("strobes not high in reset");
endmodule : rpc_monitor

bind rpc_top rpc_monitor #(.GLITCH_CYCLES(GLITCH_CYCLES), .QUAL_CYCLES(QUAL_CYCLES)) u_mon (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .ext_rst_i(ext_rst_i), .irq_i(irq_i), .wr_i(wr_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .sys_rst_o(sys_rst_o),
  .ale_weak_high_o(ale_weak_high_o), .program_fetch_strobe_weak_high_o(program_fetch_strobe_weak_high_o),
  .sfr_o(sfr_o), .status_o(status_o)
);

/* rpc_rst_src.sv */
// External reset source model driving the reset pin
`timescale 1ns/1ps
module rpc_rst_src (
  input  wire logic mclk_i,
  output logic      ext_rst_o
);
  initial ext_rst_o = 1'b0;
  // Pin high for the given clocks, then low again
  task automatic pulse(input int cycles);
    @(posedge mclk_i);
    ext_rst_o <= 1'b1;
    repeat (cycles) @(posedge mclk_i);
    ext_rst_o <= 1'b0;
  endtask : pulse
endmodule : rpc_rst_src

/* tb.sv */
// Testbench of the reset and power controller
`timescale 1ns/1ps
module tb;
  import rpc_pkg::*;
  logic          mclk_i  = 1'b0;
  logic          rstn_i  = 1'b0;
  logic          irq_i   = 1'b0;
  logic          wr_i    = 1'b0;
  logic          rd_i    = 1'b0;
  logic [3:0]    addr_i  = 4'h0;
  logic [7:0]    wdata_i = 8'h00;
  logic          ext_rst, cpu_en, per_en, osc_run, sys_rst, ale_hi, pfs_hi;
  logic [7:0]    rdata;
  rpc_sfr_view_s sfr;
  rpc_status_s   st;
  int            bad_count = 0;
  int            check_count = 0;
  int            cyc = 0;
  int            nc;
  int            np;

  always #2 mclk_i = ~mclk_i;

  rpc_top #(.GLITCH_CYCLES(4), .QUAL_CYCLES(2)) u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ext_rst_i(ext_rst), .irq_i(irq_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(per_en), .osc_run_o(osc_run), .sys_rst_o(sys_rst), .ale_weak_high_o(ale_hi),
    .program_fetch_strobe_weak_high_o(pfs_hi), .sfr_o(sfr), .status_o(st)
  );
  rpc_rst_src u_src (.mclk_i(mclk_i), .ext_rst_o(ext_rst));

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic chk_mode(input rpc_mode_e m);
    chk("mode", {6'h00, m}, {6'h00, st.mode});
  endtask : chk_mode
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask : rd
  task automatic count(input int k);
    nc = 0;
    np = 0;
    repeat (k) begin
      @(posedge mclk_i);
      #1;
      nc += int'(cpu_en);
      np += int'(per_en);
    end
  endtask : count
  task automatic wait_rst(input logic lvl);
    for (int n = 0; n < 200 && sys_rst !== lvl; n++) begin
      @(posedge mclk_i);
      #1;
    end
    chk("sys_rst", {7'h00, lvl}, {7'h00, sys_rst});
  endtask : wait_rst
  task automatic rst_vals(input logic [7:0] pwr, input logic [7:0] ser);
    for (int i = 0; i < NUM_PORTS; i++) rd(i[3:0], PORT_RST_VAL);
    rd(ADDR_SP, SP_RST_VAL);
    rd(ADDR_PWR_CTL, pwr);
    rd(ADDR_GEN_SFR, SFR_RST_VAL);
    rd(ADDR_SER_BUF, ser);
  endtask : rst_vals

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    wait_rst(1'b0);
    rst_vals(8'h00, 8'h00);
    for (int i = 0; i < NUM_PORTS; i++) wr(i[3:0], 8'h50 + i[7:0]);
    wr(ADDR_SP, 8'h33);
    wr(ADDR_GEN_SFR, 8'h44);
    wr(ADDR_SER_BUF, 8'ha5);
    wr(ADDR_PWR_CTL, 8'h10);
    wr(4'ha, 8'h77);
    rd(4'ha, READ_ZERO);
    // Glitch, then a pulse shorter than two samples
    u_src.pulse(3);
    repeat (40) @(posedge mclk_i);
    u_src.pulse(11);
    repeat (40) @(posedge mclk_i);
    rd(ADDR_SP, 8'h33);
    rd(4'h1, 8'h51);
    chk("sys_rst", 8'h00, {7'h00, sys_rst});
    // Idle: processor stops, peripherals keep running
    wr(ADDR_PWR_CTL, 8'h11);
    count(12);
    chk("cpu pulses", 8'h00, nc[7:0]);
    chk("periph pulses", 8'h06, np[7:0]);
    chk_mode(RPC_IDLE);
    @(posedge mclk_i);
    irq_i <= 1'b1;
    @(posedge mclk_i);
    irq_i <= 1'b0;
    rd(ADDR_PWR_CTL, 8'h10);
    chk_mode(RPC_RUN);
    // Power-down ignores the interrupt
    wr(ADDR_PWR_CTL, 8'h12);
    @(posedge mclk_i);
    irq_i <= 1'b1;
    count(12);
    @(posedge mclk_i);
    irq_i <= 1'b0;
    chk("osc", 8'h00, {7'h00, osc_run});
    chk("pulses", 8'h00, nc[7:0] + np[7:0]);
    chk_mode(RPC_DOWN);
    // Status read in power-down: upper nibble only, phase and state frozen
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= ADDR_STATUS;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 chk("status", {2'b00, RPC_DOWN, 4'h0}, rdata & 8'hf0);
    // Qualified reset wakes it, serial buffer and bit four kept
    u_src.pulse(48);
    wait_rst(1'b1);
    chk("strobes", 8'h03, {6'h00, ale_hi, pfs_hi});
    wait_rst(1'b0);
    rst_vals(8'h10, 8'ha5);
    chk_mode(RPC_RUN);
    chk("osc", 8'h01, {7'h00, osc_run});
    wrap_up();
  end
endmodule : tb
